/* src/csf_params.svh */
/*
  Constants for the condition flags register: address, bit positions, reset values.
  Assumes inclusion by bare name from the design modules and the checker.
*/
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH
`define CSF_FLAGS_ADDR     8'hD5
`define CSF_BIT_CARRY      7
`define CSF_BIT_ZERO       6
`define CSF_BIT_SIGN       5
`define CSF_BIT_OVFL       4
`define CSF_BIT_DEC        3
`define CSF_BIT_HALF       2
`define CSF_BIT_FAST       1
`define CSF_BIT_BANK       0
`define CSF_FLAGS_RESET    8'h00
`define CSF_FLAG_MASK      8'hFC
`endif

/* src/csf_pkg.sv */
/*
  Types shared by the condition flags register design.
  Assumes csf_params.svh is on the include path.
*/
package csf_pkg;
  typedef enum logic [2:0]
  {
    CSF_OP_NONE,
    CSF_OP_ADD,
    CSF_OP_SUB,
    CSF_OP_LOGIC
  } csf_op_e;

  typedef enum logic [1:0]
  {
    CSF_FS_IDLE,
    CSF_FS_SERVICE,
    CSF_FS_RETURN
  } csf_fast_e;
endpackage : csf_pkg

/* src/csf_flag_calc.sv */
/*
  Combinational flag computation for one eight-bit operation.
  Assumes operands are stable in the cycle the update strobe is high.
*/
`timescale 1ns/1ps
`include "csf_params.svh"
module csf_flag_calc
  import csf_pkg::*;
(
  // Operation.
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       carry_in_i,
  input  wire csf_op_e    op_i,
  // Results.
  output logic      [7:0] result_o,
  output logic      [7:0] flags_o
);
  logic [8:0] full;
  logic [4:0] nib;
  logic       ovf;

  always_comb
  begin
    full = 9'h000;
    nib  = 5'h00;
    ovf  = 1'b0;
    case (op_i)
      CSF_OP_ADD:
      begin
        full = {1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_in_i};
        nib  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, carry_in_i};
        ovf  = (a_i[7] == b_i[7]) && (full[7] != a_i[7]);
      end
      CSF_OP_SUB:
      begin
        full = {1'b0, a_i} - {1'b0, b_i} - {8'h00, carry_in_i};
        nib  = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, carry_in_i};
        ovf  = (a_i[7] != b_i[7]) && (full[7] != a_i[7]);
      end
      CSF_OP_LOGIC:
      begin
        full = {1'b0, a_i};
      end
      default:
      begin
        full = 9'h000;
      end
    endcase
    result_o                  = full[7:0];
    flags_o                   = 8'h00;
    flags_o[`CSF_BIT_CARRY]   = full[8];
    flags_o[`CSF_BIT_ZERO]    = (full[7:0] == 8'h00);
    flags_o[`CSF_BIT_SIGN]    = full[7];
    flags_o[`CSF_BIT_OVFL]    = ovf;
    flags_o[`CSF_BIT_DEC]     = (op_i == CSF_OP_SUB);
    flags_o[`CSF_BIT_HALF]    = nib[4];
  end
endmodule : csf_flag_calc

/* src/csf_flags.sv */
/*
  Processor status flags register with its register-addressed access port.
  Assumes the execution datapath presents operands with a one-cycle update strobe,
  and the interrupt sequencer pulses fast-service entry and return.
*/
`timescale 1ns/1ps
`include "csf_params.svh"
module csf_flags
  import csf_pkg::*;
(
  // Clock and reset.
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  // Operation update.
  input  wire logic       update_i,
  input  wire csf_op_e    op_i,
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       use_carry_i,
  // Register access.
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_set1_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  // Interrupt sequencer.
  input  wire logic       fast_enter_i,
  input  wire logic       interrupt_return_op_i,
  // Outputs.
  output logic      [7:0] reg_rdata_o,
  output logic      [7:0] result_o,
  output logic      [7:0] flags_o,
  output logic            bank_sel_o
);
  logic [7:0] cond_q;
  logic       fast_service_active_q;
  logic       bank_q;
  logic [7:0] calc_result;
  logic [7:0] calc_flags;
  logic       hit;

  function automatic logic flags_hit(input logic [7:0] addr, input logic set1);
    flags_hit = set1 && (addr == `CSF_FLAGS_ADDR);
  endfunction : flags_hit

  assign hit = flags_hit(reg_addr_i, reg_set1_i);

  csf_flag_calc u_calc
  (
    .a_i        (a_i),
    .b_i        (b_i),
    .carry_in_i (use_carry_i & cond_q[`CSF_BIT_CARRY]),
    .op_i       (op_i),
    .result_o   (calc_result),
    .flags_o    (calc_flags)
  );

  // Condition bits; a direct write beats the same cycle's arithmetic update.
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      cond_q <= `CSF_FLAGS_RESET;
    else if (reg_wr_i && hit)
      cond_q <= reg_wdata_i & `CSF_FLAG_MASK;
    else if (update_i && (op_i != CSF_OP_NONE))
      cond_q <= calc_flags & `CSF_FLAG_MASK;
  end

  // Software cannot write this bit; only the interrupt sequencer moves it.
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      fast_service_active_q <= 1'b0;
    else if (fast_enter_i)
      fast_service_active_q <= 1'b1;
    else if (interrupt_return_op_i)
      fast_service_active_q <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      bank_q <= 1'b0;
    else if (reg_wr_i && hit)
      bank_q <= reg_wdata_i[`CSF_BIT_BANK];
  end

  // Outputs are registered so the datapath sees stable values for a full cycle.
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= 8'h00;
      result_o    <= 8'h00;
      flags_o     <= 8'h00;
      bank_sel_o  <= 1'b0;
    end
    else
    begin
      if (reg_rd_i && hit)
        reg_rdata_o <= {cond_q[7:2], fast_service_active_q, bank_q};
      else if (reg_rd_i)
        reg_rdata_o <= 8'h00;
      result_o   <= calc_result;
      flags_o    <= {cond_q[7:2], fast_service_active_q, bank_q};
      bank_sel_o <= bank_q;
    end
  end
endmodule : csf_flags

/* verification/csf_flags_assertions.sv */
/* Checker for csf_flags, bound to its ports.
   Assumes flags are predicted only for add and subtract without carry in. */
`timescale 1ns/1ps
`include "csf_params.svh"
module csf_flags_assertions
  import csf_pkg::*;
(
  // Watched ports.
  input wire logic clock_i, resetn_i, update_i, use_carry_i, reg_set1_i, reg_wr_i, fast_enter_i, bank_sel_o,
  input wire csf_op_e op_i,
  input wire logic [7:0] a_i, b_i, reg_addr_i, reg_wdata_i, flags_o
);
  wire hit = reg_wr_i && reg_set1_i && reg_addr_i == `CSF_FLAGS_ADDR;
  wire sub = op_i == CSF_OP_SUB;
  wire upd = update_i && !reg_wr_i && !use_carry_i && (sub || op_i == CSF_OP_ADD);
  wire [8:0] r9 = sub ? a_i - b_i : a_i + b_i;
  wire [4:0] h5 = sub ? a_i[3:0] - b_i[3:0] : a_i[3:0] + b_i[3:0];
  wire [7:0] ex = {r9[8], r9[7:0] == 8'h00, r9[7], (a_i[7] ^ r9[7]) & (a_i[7] ^ b_i[7] ^ !sub), sub, h5[4], 2'h0};
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // Two edges: one to store the flags, one to copy them out.
  property flag_p(int b);
    upd |-> ##2 flags_o[b] == $past(ex[b], 2);
  endproperty
  carry_a: assert property (flag_p(7)) else $error("carry bad");
  zero_a: assert property (flag_p(6)) else $error("zero bad");
  sign_a: assert property (flag_p(5)) else $error("sign bad");
  ovfl_a: assert property (flag_p(4)) else $error("overflow bad");
  dec_a: assert property (flag_p(3)) else $error("decimal bad");
  half_a: assert property (flag_p(2)) else $error("half bad");
  fast_a: assert property (fast_enter_i |-> ##2 flags_o[1]) else $error("fast bad");
  bank_a: assert property (hit |-> ##2 bank_sel_o == $past(reg_wdata_i[0], 2)) else $error("bank bad");
  write_wins_a: assert property (hit && update_i |-> ##2 flags_o[7:2] == $past(reg_wdata_i[7:2], 2)) else $error("lost");
  cover property (upd && sub);
  cover property (hit && update_i);
  cover property (fast_enter_i);
endmodule : csf_flags_assertions
bind csf_flags csf_flags_assertions chk_u (.*);

/* verification/csf_flags_tb.sv */
/* Bench for csf_flags: flag results, register access and the fast-service bit.
   Assumes the design and its checker are compiled first. */
`timescale 1ns/1ps
module csf_flags_tb
  import csf_pkg::*;
;
  logic clock_i = '0, resetn_i = '0, use_carry_i = '0, bank_sel_o;
  logic [5:0] ctl = '0;
  logic [31:0] v = '0;
  wire logic update_i, reg_wr_i, reg_set1_i, fast_enter_i, interrupt_return_op_i, reg_rd_i;
  wire logic [7:0] a_i, b_i, reg_addr_i, reg_wdata_i;
  logic [7:0] reg_rdata_o, result_o, flags_o;
  csf_op_e op_i = CSF_OP_NONE;
  int err_total = 0, checks_done = 0;
  assign {update_i, reg_wr_i, reg_set1_i, fast_enter_i, interrupt_return_op_i, reg_rd_i} = ctl;
  assign {a_i, b_i, reg_addr_i, reg_wdata_i} = v;
  csf_flags dut_u (.*);
  initial forever #12.5 clock_i = ~clock_i;
  task chk(input string n, input logic [7:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One request cycle, then one more edge so the copied-out flags have landed.
  task step(input csf_op_e o, input logic [31:0] w, input logic [5:0] c);
    @(negedge clock_i);
    op_i = o;
    v = w;
    ctl = c;
    @(negedge clock_i);
    ctl = '0;
    @(negedge clock_i);
  endtask : step
  task automatic arith;
    logic [27:0] t [8] = '{28'h17F0134, 28'h1FF01C4, 28'h20001AC, 28'h280011C, 28'h2050548, 28'h3000040,
      28'h3800020, 28'h0FF0120};
    logic [7:0] r [8] = '{8'h80, 8'h00, 8'hFF, 8'h7F, 8'h00, 8'h00, 8'h80, 8'h00};
    foreach (t[i])
    begin
      step(csf_op_e'(t[i][26:24]), {t[i][23:8], 16'h0000}, 6'h20);
      chk("flags", t[i][7:0], flags_o);
      chk("result", r[i], result_o);
    end
    // A borrow leaves carry set, so the next add with carry in crosses into the sign bit.
    step(CSF_OP_SUB, 32'h00010000, 6'h20);
    chk("borrow", 8'hAC, flags_o);
    use_carry_i = 1'b1;
    step(CSF_OP_ADD, 32'h7F000000, 6'h20);
    use_carry_i = 1'b0;
    chk("carry in", 8'h34, flags_o);
  endtask : arith
  task regs;
    step(CSF_OP_NONE, 32'h0000D5FF, 6'h18);
    chk("written", 8'hFD, flags_o);
    chk("bank on", 8'h01, {7'h00, bank_sel_o});
    step(CSF_OP_NONE, 32'h0000D400, 6'h18);
    step(CSF_OP_NONE, 32'h0000D500, 6'h09);
    chk("rdata", 8'hFD, reg_rdata_o);
    step(CSF_OP_NONE, 32'h0000D400, 6'h09);
    chk("miss", 8'h00, reg_rdata_o);
    step(CSF_OP_ADD, 32'hFF01D500, 6'h38);
    chk("wins", 8'h00, flags_o);
    chk("bank off", 8'h00, {7'h00, bank_sel_o});
  endtask : regs
  task fast;
    step(CSF_OP_NONE, 32'h0, 6'h04);
    chk("fast on", 8'h02, flags_o);
    step(CSF_OP_NONE, 32'h0, 6'h02);
    chk("fast off", 8'h00, flags_o);
    step(CSF_OP_NONE, 32'h0, 6'h06);
    chk("fast both", 8'h02, flags_o);
    step(CSF_OP_NONE, 32'h0, 6'h02);
    chk("fast clear", 8'h00, flags_o);
  endtask : fast
  task give_verdict;
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (5) @(negedge clock_i);
    resetn_i = 1'h1;
    arith();
    regs();
    fast();
    give_verdict();
  end
endmodule : csf_flags_tb
